// >>> rtl/rsse_consts.vh
// Purpose: constants for the rotate / fill / sleep execute block
// Assumes: 16-bit instruction word, 8-bit data, 4-phase instruction cycle
// Notes: definitions only
`ifndef RSSE_CONSTS_VH
`define RSSE_CONSTS_VH
`define RSSE_OPC_ROT_HI 6'h10
`define RSSE_OPC_FILL_HI 7'h34
`define RSSE_OPC_SLEEP 16'h0003
`define RSSE_FILL_VALUE 8'hff
`define RSSE_WDOG_CLEAR 8'h00
`define RSSE_POST_CLEAR 8'h00
`define RSSE_IDX_LIMIT 8'h5f
`define RSSE_DEST_BIT 9
`define RSSE_BANK_BIT 8
`define RSSE_PH_DECODE 2'h0
`define RSSE_PH_READ 2'h1
`define RSSE_PH_PROC 2'h2
`define RSSE_PH_WRITE 2'h3
`define RSSE_RST_TO_N 1'h1
`define RSSE_RST_PD_N 1'h1
`define RSSE_ACCESS_HI_BASE 4'hf
`endif

// >>> rtl/rsse_phase_gen.v
// Purpose: four-phase instruction cycle sequencer
// Assumes: one clock, a two-bit count marks each phase
// Notes: phase counter stops while halted
`timescale 1ns/100ps
`default_nettype none
`include "rsse_consts.vh"
module rsse_phase_gen (
    // clock and reset
    input wire ref_clk_i,
    input wire sys_rst_i,
    // control
    input wire run_i,
    // phase
    output reg [1:0] phase_o
);
    // advance one phase per clock while running
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_o <= `RSSE_PH_DECODE;
        end else if (run_i) begin
            phase_o <= phase_o + 2'h1;
        end
    end
endmodule // rsse_phase_gen
`default_nettype wire

// >>> rtl/rsse_exec.v
// Purpose: execute rotate right (no carry), fill ones and sleep
// Assumes: register file and watchdog outside; inputs synchronous
// Notes: one instruction per four-phase cycle, phases 1..4 = 0..3
// Operation
// RULE_01 - rotate right, bit0 to bit7, carry kept
// RULE_02 - rotate with d clear writes working register
// RULE_03 - d 0 to working, 1 to file
// RULE_04 - fill writes all ones, no flags changed
// RULE_05 - bank bit picks access or selected bank
// RULE_06 - indexed literal offset when a=0, ext, f<=5f
// RULE_07 - sleep opcode is fixed 16'h0003
// RULE_08 - sleep clears power-down flag
// RULE_09 - sleep sets time-out flag
// RULE_10 - sleep clears watchdog and postscaler
// RULE_11 - sleep halts core in last phase
// RULE_12 - watchdog wake clears time-out flag
// RULE_13 - one word, one cycle, four phases
`timescale 1ns/100ps
`default_nettype none
`include "rsse_consts.vh"
module rsse_exec (
    // clock and reset
    input wire ref_clk_i,
    input wire sys_rst_i,
    // instruction and configuration
    input wire [15:0] instr_i,
    input wire ext_set_en_i,
    input wire [3:0] bank_select_reg_i,
    input wire [7:0] index_base_i,
    // register file read data
    input wire [7:0] file_rdata_i,
    // wake events
    input wire wake_i,
    input wire wake_watchdog_i,
    // register file access
    output reg [11:0] file_addr_o,
    output reg file_rd_o,
    output reg file_we_o,
    output reg [7:0] file_wdata_o,
    // working register write
    output reg work_we_o,
    output reg [7:0] work_wdata_o,
    // status flags
    output reg nz_we_o,
    output reg neg_o,
    output reg zero_o,
    output reg timeout_flag_n_o,
    output reg powerdown_flag_n_o,
    // watchdog control
    output reg watchdog_clear_o,
    output reg [7:0] watchdog_counter_o,
    output reg [7:0] post_count_o,
    // state
    output reg sleeping_o,
    output reg [1:0] phase_o,
    output reg [1:0] op_o
);
    // operation codes, also shown one edge late on op_o
    localparam OP_NONE = 2'h0;
    localparam OP_ROT = 2'h1;
    localparam OP_FILL = 2'h2;
    localparam OP_SLEEP = 2'h3;

    wire [1:0] phase;
    reg [1:0] op;
    reg [15:0] ir;
    reg [7:0] data;
    reg [1:0] next_op;
    reg [11:0] next_addr;

    // decode one instruction word into an operation
    // any word that is not one of the three is a no-operation
    function [1:0] rsse_decode;
        input [15:0] w;
        begin
            if (w == `RSSE_OPC_SLEEP) begin
                rsse_decode = OP_SLEEP; // [RULE_07]
            end else if (w[15:10] == `RSSE_OPC_ROT_HI) begin
                rsse_decode = OP_ROT;
            end else if (w[15:9] == `RSSE_OPC_FILL_HI) begin
                rsse_decode = OP_FILL; // [RULE_04]
            end else begin
                rsse_decode = OP_NONE;
            end
        end
    endfunction


    // phase sequencer, frozen while asleep
    // it sees sleeping_o one edge late, so the write edge of a sleep
    // still wraps it to decode, where it rests until a wake event
    rsse_phase_gen u_phase (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(~sleeping_o),
        .phase_o(phase)
    );


    // effective address: access bank, selected bank or indexed offset
    // the indexed test comes first: with a=0 and the extended set on it
    // overrides the access bank for offsets up to the limit
    always @* begin
        next_op = rsse_decode(instr_i);
        if (!instr_i[`RSSE_BANK_BIT] && ext_set_en_i &&
            instr_i[7:0] <= `RSSE_IDX_LIMIT) begin
            next_addr = {4'h0, index_base_i + instr_i[7:0]}; // [RULE_06]
        end else if (instr_i[`RSSE_BANK_BIT]) begin
            next_addr = {bank_select_reg_i, instr_i[7:0]}; // [RULE_05]
        end else if (instr_i[7:0] > `RSSE_IDX_LIMIT) begin
            next_addr = {`RSSE_ACCESS_HI_BASE, instr_i[7:0]}; // [RULE_05]
        end else begin
            next_addr = {4'h0, instr_i[7:0]}; // [RULE_05]
        end
    end


    // four-phase execution: decode, read, process, write
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            op <= OP_NONE;
            ir <= 16'h0000;
            data <= 8'h00;
            file_addr_o <= 12'h000;
            file_rd_o <= 1'b0;
            file_we_o <= 1'b0;
            file_wdata_o <= 8'h00;
            work_we_o <= 1'b0;
            work_wdata_o <= 8'h00;
            nz_we_o <= 1'b0;
            neg_o <= 1'b0;
            zero_o <= 1'b0;
            timeout_flag_n_o <= `RSSE_RST_TO_N;
            powerdown_flag_n_o <= `RSSE_RST_PD_N;
            watchdog_clear_o <= 1'b0;
            watchdog_counter_o <= 8'h00;
            post_count_o <= 8'h00;
            sleeping_o <= 1'b0;
            phase_o <= `RSSE_PH_DECODE;
            op_o <= OP_NONE;
        end else begin
            file_rd_o <= 1'b0;
            file_we_o <= 1'b0;
            work_we_o <= 1'b0;
            nz_we_o <= 1'b0;
            watchdog_clear_o <= 1'b0;
            phase_o <= phase;
            op_o <= op;
            if (sleeping_o) begin
                // instr_i is ignored here and the phase stays at decode
                // leave sleep on a wake event
                if (wake_i || wake_watchdog_i) begin
                    sleeping_o <= 1'b0;
                end
                if (wake_watchdog_i) begin
                    timeout_flag_n_o <= 1'b0; // [RULE_12]
                end
            end else begin
                case (phase) // [RULE_13]
                    `RSSE_PH_DECODE: begin
                        // hold the word and its address for the cycle
                        ir <= instr_i;
                        op <= next_op;
                        file_addr_o <= next_addr;
                    end
                    `RSSE_PH_READ: begin
                        // sleep reads nothing in this phase
                        file_rd_o <= (op == OP_ROT) || (op == OP_FILL);
                    end
                    `RSSE_PH_PROC: begin
                        if (op == OP_ROT) begin
                            // carry is not touched
                            data <= {file_rdata_i[0], file_rdata_i[7:1]}; // [RULE_01]
                        end else begin
                            data <= `RSSE_FILL_VALUE; // [RULE_04]
                        end
                        // sleep side effects land one edge before the halt
                        if (op == OP_SLEEP) begin
                            powerdown_flag_n_o <= 1'b0; // [RULE_08]
                            timeout_flag_n_o <= 1'b1; // [RULE_09]
                            watchdog_counter_o <= `RSSE_WDOG_CLEAR; // [RULE_10]
                            post_count_o <= `RSSE_POST_CLEAR; // [RULE_10]
                            watchdog_clear_o <= 1'b1; // [RULE_10]
                        end
                    end
                    `RSSE_PH_WRITE: begin
                        case (op)
                            OP_ROT: begin
                                if (ir[`RSSE_DEST_BIT]) begin
                                    file_we_o <= 1'b1; // [RULE_01] [RULE_03]
                                    file_wdata_o <= data;
                                end else begin
                                    work_we_o <= 1'b1; // [RULE_02] [RULE_03]
                                    work_wdata_o <= data;
                                end
                                // negative and zero follow the result
                                nz_we_o <= 1'b1;
                                neg_o <= data[7];
                                zero_o <= (data == 8'h00);
                            end
                            OP_FILL: begin
                                // fill leaves every status flag alone
                                file_we_o <= 1'b1; // [RULE_04]
                                file_wdata_o <= data;
                            end
                            OP_SLEEP: begin
                                // halt; the wake branch runs from here on
                                sleeping_o <= 1'b1; // [RULE_11]
                            end
                            default: begin
                                // unknown words finish with no side effect
                                op <= OP_NONE;
                            end
                        endcase
                    end
                    default: begin
                        // phase is two bits wide, so never taken
                        op <= op;
                    end
                endcase
            end
        end
    end
endmodule // rsse_exec
`default_nettype wire

// >>> sim/rsse_exec_sva.sv
// Purpose: port-level checker for rsse_exec
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every rsse_exec instance
`timescale 1ns/100ps
`default_nettype none
module rsse_exec_sva (
    // clock and reset
    input wire ref_clk_i,
    input wire sys_rst_i,
    // watched signals
    input wire wake_i,
    input wire wake_watchdog_i,
    input wire file_we_o,
    input wire [7:0] file_wdata_o,
    input wire work_we_o,
    input wire nz_we_o,
    input wire timeout_flag_n_o,
    input wire powerdown_flag_n_o,
    input wire watchdog_clear_o,
    input wire [7:0] watchdog_counter_o,
    input wire [7:0] post_count_o,
    input wire sleeping_o,
    input wire [1:0] op_o
);
    // one clock domain for all properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_fill_ones: assert property (file_we_o && op_o == 2'h2 |->
        file_wdata_o == 8'hff) else $error("fill wrote other than ones");
    a_fill_no_flags: assert property (op_o == 2'h2 |-> !nz_we_o)
        else $error("fill touched status flags");
    a_one_dest: assert property (work_we_o |-> !file_we_o)
        else $error("result written to both destinations");
    a_sleep_flags: assert property ($rose(sleeping_o) |->
        !powerdown_flag_n_o && timeout_flag_n_o) else $error("sleep flags");
    a_sleep_wdog: assert property ($rose(sleeping_o) |->
        watchdog_counter_o == 8'h00 && post_count_o == 8'h00)
        else $error("watchdog not cleared on sleep");
    a_clear_then_sleep: assert property (watchdog_clear_o |->
        ##[1:2] sleeping_o) else $error("sleep not entered after clear");
    a_wake_clears_to: assert property (sleeping_o &&
        wake_watchdog_i |-> ##[1:2] !timeout_flag_n_o)
        else $error("watchdog wake kept time-out flag");
    a_sleep_no_write: assert property (sleeping_o |->
        !file_we_o && !work_we_o) else $error("write while asleep");
endmodule // rsse_exec_sva
bind rsse_exec rsse_exec_sva u_sva (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .wake_i(wake_i), .wake_watchdog_i(wake_watchdog_i),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .work_we_o(work_we_o),
    .nz_we_o(nz_we_o), .timeout_flag_n_o(timeout_flag_n_o),
    .powerdown_flag_n_o(powerdown_flag_n_o),
    .watchdog_clear_o(watchdog_clear_o),
    .watchdog_counter_o(watchdog_counter_o), .post_count_o(post_count_o),
    .sleeping_o(sleeping_o), .op_o(op_o));
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: self-checking bench for rsse_exec
// Assumes: inputs change on the falling edge, one instruction per 4 clocks
// Notes: rows hold instr, rdata, bank, ext, file we, work we, data, addr
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // stimulus
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] instr = 16'h0000;
    logic [7:0] rdata = 8'h00;
    logic [3:0] bank = 4'h0;
    logic ext = 1'b0;
    logic wk = 1'b0;
    logic wkw = 1'b0;
    // observed
    wire [11:0] addr;
    wire [7:0] fwd;
    wire [7:0] wwd;
    wire [7:0] wdc;
    wire [7:0] pst;
    wire [1:0] ph;
    wire fwe, wwe, slp, to_n, pd_n;
    wire frd, nzwe, neg, zer;
    // bookkeeping
    int fails = 0;
    int total_checks = 0;
    logic [11:0] ga, ea;
    logic [7:0] gd, ed;
    logic gf, gw, ef, ew;
    logic gr, gn, gneg, gzer, er, en;
    logic [1:0] gp;
    logic [50:0] rows [0:8] = '{
        {16'h4220, 8'hd7, 4'h0, 1'h0, 1'h1, 1'h0, 8'heb, 12'h020},
        {16'h4020, 8'hd7, 4'h0, 1'h0, 1'h0, 1'h1, 8'heb, 12'h020},
        {16'h4320, 8'h01, 4'h3, 1'h0, 1'h1, 1'h0, 8'h80, 12'h320},
        {16'h4205, 8'h00, 4'h0, 1'h0, 1'h1, 1'h0, 8'h00, 12'h005},
        {16'h68a0, 8'h00, 4'h0, 1'h0, 1'h1, 1'h0, 8'hff, 12'hfa0},
        {16'h695a, 8'h5a, 4'hc, 1'h0, 1'h1, 1'h0, 8'hff, 12'hc5a},
        {16'h685f, 8'h00, 4'h0, 1'h1, 1'h1, 1'h0, 8'hff, 12'h09f},
        {16'h6860, 8'h00, 4'h0, 1'h1, 1'h1, 1'h0, 8'hff, 12'hf60},
        {16'h0004, 8'h00, 4'h0, 1'h0, 1'h0, 1'h0, 8'h00, 12'h000}};
    rsse_exec u_dut (.ref_clk_i(clk), .sys_rst_i(rst), .instr_i(instr),
        .ext_set_en_i(ext), .bank_select_reg_i(bank), .index_base_i(8'h40),
        .file_rdata_i(rdata), .wake_i(wk), .wake_watchdog_i(wkw),
        .file_addr_o(addr), .file_rd_o(frd), .file_we_o(fwe),
        .file_wdata_o(fwd), .work_we_o(wwe), .work_wdata_o(wwd),
        .nz_we_o(nzwe), .neg_o(neg), .zero_o(zer),
        .timeout_flag_n_o(to_n), .powerdown_flag_n_o(pd_n),
        .watchdog_clear_o(), .watchdog_counter_o(wdc), .post_count_o(pst),
        .sleeping_o(slp), .phase_o(ph), .op_o());
    // free-running 100 MHz clock
    always #5 clk = ~clk;
    task automatic check(input string n, input logic [11:0] s, e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard: the whole run needs under 900 ns
    initial begin
        #5000;
        fails++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        check("pd_n in reset", pd_n, 1'b1);
        check("to_n in reset", to_n, 1'b1);
        check("sleeping in reset", slp, 1'b0);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            {instr, rdata, bank, ext, ef, ew, ed, ea} = rows[i];
            {gf, gw, gd, ga, gr, gn, gneg, gzer, gp} = '0;
            repeat (4) begin
                @(negedge clk);
                if (fwe === 1'b1) {gf, gd, ga, gp} = {1'b1, fwd, addr, ph};
                if (wwe === 1'b1) {gw, gd, ga, gp} = {1'b1, wwd, addr, ph};
                if (frd === 1'b1) gr = 1'b1;
                if (nzwe === 1'b1) {gn, gneg, gzer} = {1'b1, neg, zer};
            end
            // every row that writes reads f first; rotates report N and Z
            er = ef | ew;
            en = (instr[15:10] == 6'h10);
            check("file_we", gf, ef);
            check("work_we", gw, ew);
            check("file_rd", gr, er);
            check("nz_we", gn, en);
            if (ef | ew) check("data", gd, ed);
            if (ef | ew) check("addr", ga, ea);
            if (ef | ew) check("write phase", gp, 2'h3);
            if (en) check("neg", gneg, ed[7]);
            if (en) check("zero", gzer, ed == 8'h00);
        end
        // sleep: power-down flag cleared, time-out flag set, watchdog cleared, then halt
        instr = 16'h0003;
        repeat (4) @(negedge clk);
        check("sleeping", slp, 1'b1);
        check("pd_n", pd_n, 1'b0);
        check("to_n", to_n, 1'b1);
        check("watchdog", wdc, 8'h00);
        check("postscaler", pst, 8'h00);
        // a fill offered while asleep must not run
        instr = 16'h68a0;
        gf = 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (fwe !== 1'b0) gf = 1'b1;
        end
        check("write asleep", gf, 1'b0);
        check("still asleep", slp, 1'b1);
        // watchdog wake clears the time-out flag
        {wk, wkw} = 2'b11;
        @(negedge clk);
        {wk, wkw} = 2'b00;
        @(negedge clk);
        check("awake", slp, 1'b0);
        check("to_n after wake", to_n, 1'b0);
        // the pending fill runs, then a second sleep sets the flag again
        instr = 16'h0003;
        repeat (7) @(negedge clk);
        check("asleep again", slp, 1'b1);
        check("to_n set again", to_n, 1'b1);
        // a wake that is not the watchdog keeps the time-out flag
        wk = 1'b1;
        @(negedge clk);
        wk = 1'b0;
        @(negedge clk);
        check("awake plain", slp, 1'b0);
        check("to_n plain wake", to_n, 1'b1);
        repeat (3) @(negedge clk);
        check("third sleep", slp, 1'b1);
        // reset in mid-run while asleep
        rst = 1'b1;
        @(negedge clk);
        check("sleeping after reset", slp, 1'b0);
        check("pd_n after reset", pd_n, 1'b1);
        rst = 1'b0;
        {instr, rdata, bank, ext, ef, ew, ed, ea} = rows[0];
        {gf, gd} = '0;
        repeat (4) begin
            @(negedge clk);
            if (fwe === 1'b1) {gf, gd} = {1'b1, fwd};
        end
        check("write after reset", gf, 1'b1);
        check("data after reset", gd, 8'heb);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
